// ---- cbrc_bus_node.sv ----
/* Other nodes on the bus: they leave it recessive while a bit tick runs.
   Assumes the block's clock; the tick stands still while run is low. */
`timescale 1ns/1ps
module cbrc_bus_node #(
    parameter int TICK_DIV = 2
) (
    // Control
    input  wire logic clk,
    input  wire logic run,
    // Bus side
    output logic      bitTick,
    output logic      canRx
);
    int div = 0;
    initial bitTick = 1'b0;
    // Idle nodes never drive dominant, so the line rests at its recessive level
    assign canRx = 1'b1;
    always @(posedge clk) begin
        div <= (run && div < TICK_DIV - 1) ? div + 1 : 0;
        bitTick <= run && div == TICK_DIV - 1;
    end
endmodule : cbrc_bus_node

// ---- cbrc_ctrl.sv ----
/*
 * Control register upper bits of one CAN channel: forced bus-off return, recovery policies,
 * automatic halt entry, error counters and the sleep request.
 * Assumes the protocol engine supplies error events and a bit tick on clk, and the bus level on a pin.
 */
// What this block does
// - Writing forced-return 1 during bus-off returns the channel to error-active at once.
// - The forced-return bit clears itself and always reads zero.
// - Forced return zeroes both error counters and clears bus-off status only.
// - Forced return raises no bus-off recovery interrupt request.
// - Policy 00 rejoins after 128 runs of 11 recessive bits, then requests interrupt.
// - Policy 01 sets halt at bus-off entry, zeroes counters, no interrupt.
// - Policy 10 sets halt at entry, halts after recovery, interrupts, zeroes counters.
// - Policy 11 halts during bus-off when software writes halt, zeroes counters, no interrupt.
// - Policy 11 recovery completing before halt request still raises the interrupt.
// - A CPU reset-mode request beats a simultaneous automatic halt entry.
// - Sleep bit 1 enters sleep, 0 leaves; it reads 1 after reset.
// - Mode field: 00 operation, 01 reset, 10 halt, 11 forced reset.
`timescale 1ns/1ps
module cbrc_ctrl (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // CPU register port
    input  wire cbrc_pkg::cbrc_req_type regReq,
    output logic [15:0]                regRdata,
    // Protocol engine
    input  wire cbrc_pkg::cbrc_event_type errEvent,
    input  wire logic                  bitTick,
    input  wire logic                  canRx,
    // Channel status
    output logic                       busoffStatusFlag,
    output logic                       errorPassive,
    output logic [1:0]                 modeActive,
    output logic                       sleepActive,
    output logic                       recoveryIrq
);

    typedef struct packed {
        // Two-stage synchroniser for the asynchronous bus pin
        logic [1:0]  rxSync;
        logic [1:0]  policy;
        logic        sleepReq;
        logic [1:0]  operatingMode;
        logic [7:0]  lowCtrl;
        logic [7:0]  receiveErrorCounter;
        logic [7:0]  transmitErrorCounter;
        logic        busOff;
        // Set at bus-off entry under policy 01, or by a halt write during bus-off under policy 11; suppresses the recovery request
        logic        haltedInBusOff;
        logic        errPassive;
        logic        recoveryIrq;
        logic [15:0] rdata;
        logic [1:0]  modeActive;
    } cbrc_state_type;

    cbrc_state_type state;
    cbrc_state_type next_state;
    logic           recoveryDone;

    function automatic logic isResetMode(input logic [1:0] m);
        isResetMode = (m == cbrc_pkg::MODE_RESET) || (m == cbrc_pkg::MODE_FORCED);
    endfunction : isResetMode

    function automatic logic [15:0] ctrlImage(input cbrc_state_type s);
        ctrlImage = {2'b00, 1'b0, s.policy, s.sleepReq, s.operatingMode, s.lowCtrl};
    endfunction : ctrlImage

    cbrc_recovery_seq u_seq (
        .clk       (clk),
        .resetn    (resetn),
        .enable    (state.busOff),
        .bitTick   (bitTick),
        .recessive (state.rxSync[1]),
        .done      (recoveryDone)
    );

    always_comb begin
        logic        ctrlWr;
        logic        hiWr;
        logic [7:0]  hiByte;
        logic        cpuResetReq;
        logic        cpuHaltReq;
        logic [8:0]  tecSum;
        logic [8:0]  recSum;
        ctrlWr      = 1'b0;
        hiWr        = 1'b0;
        hiByte      = 8'h00;
        cpuResetReq = 1'b0;
        cpuHaltReq  = 1'b0;
        tecSum      = 9'h000;
        recSum      = 9'h000;
        next_state  = state;
        next_state.rxSync      = {state.rxSync[0], canRx};
        next_state.recoveryIrq = 1'b0;

        ctrlWr = regReq.write && (regReq.addr == cbrc_pkg::ADDR_CTRL);
        hiWr   = ctrlWr && regReq.byteEn[1];
        hiByte = regReq.wdata[15:8] & ~cbrc_pkg::RESERVED_MASK[15:8];

        // Low byte is held only; time-stamp reset bit is a strobe and reads zero
        if (ctrlWr && regReq.byteEn[0]) begin
            next_state.lowCtrl = regReq.wdata[7:0];
            next_state.lowCtrl[cbrc_pkg::BIT_TS_RESET] = 1'b0;
        end
        if (hiWr) begin
            next_state.policy        = hiByte[cbrc_pkg::POS_POLICY - 8 +: 2];
            next_state.sleepReq      = hiByte[cbrc_pkg::BIT_SLEEP - 8];
            next_state.operatingMode = hiByte[cbrc_pkg::POS_MODE - 8 +: 2];
            cpuResetReq = isResetMode(hiByte[cbrc_pkg::POS_MODE - 8 +: 2]);
            cpuHaltReq  = hiByte[cbrc_pkg::POS_MODE - 8 +: 2] == cbrc_pkg::MODE_HALT;
        end

        // Counters follow the engine only while on the bus
        tecSum = {1'b0, state.transmitErrorCounter} + {5'h00, errEvent.txInc};
        recSum = {1'b0, state.receiveErrorCounter} + {5'h00, errEvent.rxInc};
        if (!state.busOff) begin
            if (errEvent.txDec && state.transmitErrorCounter != 8'h00) begin
                next_state.transmitErrorCounter = state.transmitErrorCounter - 8'h01;
            end else begin
                next_state.transmitErrorCounter = tecSum[8] ? 8'hff : tecSum[7:0];
            end
            if (errEvent.rxDec && state.receiveErrorCounter != 8'h00) begin
                next_state.receiveErrorCounter = state.receiveErrorCounter - 8'h01;
            end else begin
                next_state.receiveErrorCounter = recSum[8] ? 8'hff : recSum[7:0];
            end
            if (tecSum > cbrc_pkg::BUSOFF_LIMIT) begin
                next_state.busOff         = 1'b1;
                next_state.haltedInBusOff = 1'b0;
                if (!cpuResetReq && state.policy != cbrc_pkg::POLICY_NORMAL
                        && state.policy != cbrc_pkg::POLICY_PROGRAM) begin
                    next_state.operatingMode = cbrc_pkg::MODE_HALT;
                end
                if (state.policy == cbrc_pkg::POLICY_HALT_ENTRY) begin
                    next_state.haltedInBusOff       = 1'b1;
                    next_state.transmitErrorCounter = cbrc_pkg::COUNT_RESET;
                    next_state.receiveErrorCounter  = cbrc_pkg::COUNT_RESET;
                end
            end
        end else if (hiWr && hiByte[cbrc_pkg::BIT_FORCED_RETURN - 8]) begin
            // Nothing but the counters, the bus-off flag and haltedInBusOff move here
            next_state.busOff               = 1'b0;
            next_state.haltedInBusOff       = 1'b0;
            next_state.transmitErrorCounter = cbrc_pkg::COUNT_RESET;
            next_state.receiveErrorCounter  = cbrc_pkg::COUNT_RESET;
            next_state.recoveryIrq          = 1'b0;
        end else begin
            if (cpuHaltReq && state.policy == cbrc_pkg::POLICY_PROGRAM && !state.haltedInBusOff) begin
                next_state.haltedInBusOff       = 1'b1;
                next_state.transmitErrorCounter = cbrc_pkg::COUNT_RESET;
                next_state.receiveErrorCounter  = cbrc_pkg::COUNT_RESET;
            end
            if (recoveryDone) begin
                next_state.busOff         = 1'b0;
                next_state.haltedInBusOff = 1'b0;
                // Halt requested in this same cycle counts as taken first
                next_state.recoveryIrq = !state.haltedInBusOff
                    && !(cpuHaltReq && state.policy == cbrc_pkg::POLICY_PROGRAM);
                if (state.policy == cbrc_pkg::POLICY_HALT_END) begin
                    next_state.transmitErrorCounter = cbrc_pkg::COUNT_RESET;
                    next_state.receiveErrorCounter  = cbrc_pkg::COUNT_RESET;
                    if (!cpuResetReq && !isResetMode(state.operatingMode)) begin
                        next_state.operatingMode = cbrc_pkg::MODE_HALT;
                    end
                end
            end
        end

        // Halt under policy 10 only takes effect once bus-off has ended
        if (next_state.busOff && next_state.operatingMode == cbrc_pkg::MODE_HALT
                && state.policy == cbrc_pkg::POLICY_HALT_END) begin
            next_state.modeActive = cbrc_pkg::MODE_OPERATION;
        end else begin
            next_state.modeActive = next_state.operatingMode;
        end

        // Passive flag is taken from the next counts so the pin comes from a flop
        next_state.errPassive = !next_state.busOff
            && ((next_state.transmitErrorCounter > cbrc_pkg::PASSIVE_LIMIT)
            || (next_state.receiveErrorCounter > cbrc_pkg::PASSIVE_LIMIT));

        // Read data is registered; forced-return bit always reads zero
        next_state.rdata = 16'h0000;
        if (regReq.read) begin
            case (regReq.addr)
                cbrc_pkg::ADDR_CTRL: next_state.rdata = ctrlImage(state);
                cbrc_pkg::ADDR_REC:  next_state.rdata = {8'h00, state.receiveErrorCounter};
                cbrc_pkg::ADDR_TEC:  next_state.rdata = {8'h00, state.transmitErrorCounter};
                default:             next_state.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state                      <= '0;
            state.policy               <= cbrc_pkg::CTRL_RESET[cbrc_pkg::POS_POLICY +: 2];
            state.sleepReq             <= cbrc_pkg::CTRL_RESET[cbrc_pkg::BIT_SLEEP];
            state.operatingMode        <= cbrc_pkg::CTRL_RESET[cbrc_pkg::POS_MODE +: 2];
            state.modeActive           <= cbrc_pkg::CTRL_RESET[cbrc_pkg::POS_MODE +: 2];
            state.lowCtrl              <= cbrc_pkg::CTRL_RESET[7:0];
            state.receiveErrorCounter  <= cbrc_pkg::COUNT_RESET;
            state.transmitErrorCounter <= cbrc_pkg::COUNT_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign regRdata         = state.rdata;
    assign busoffStatusFlag = state.busOff;
    assign modeActive       = state.modeActive;
    assign sleepActive      = state.sleepReq;
    assign recoveryIrq      = state.recoveryIrq;
    assign errorPassive     = state.errPassive;

endmodule : cbrc_ctrl

// ---- cbrc_ctrl_props.sv ----
/* Concurrent checks on the ports of the channel control block.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module cbrc_ctrl_props (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     resetn,
    // Register and engine side
    input wire cbrc_pkg::cbrc_req_type   regReq,
    input wire logic [15:0]              regRdata,
    input wire cbrc_pkg::cbrc_event_type errEvent,
    input wire logic                     bitTick,
    input wire logic                     canRx,
    // Status
    input wire logic                     busoffStatusFlag,
    input wire logic                     errorPassive,
    input wire logic [1:0]               modeActive,
    input wire logic                     sleepActive,
    input wire logic                     recoveryIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic wrCtl;
    assign wrCtl = regReq.write && regReq.addr == cbrc_pkg::ADDR_CTRL && regReq.byteEn[1];
    property p_reset_state;
        $rose(resetn) |-> modeActive == 2'b01 && sleepActive && !busoffStatusFlag && !recoveryIrq;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("State after reset wrong");
    property p_irq_pulse;
        recoveryIrq |-> $fell(busoffStatusFlag) ##1 !recoveryIrq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("Recovery request not a single pulse at exit");
    property p_forced;
        wrCtl && regReq.wdata[13] && busoffStatusFlag |=> !busoffStatusFlag && !recoveryIrq;
    endproperty
    a_forced: assert property (p_forced) else $error("Forced return did not leave bus-off quietly");
    property p_sleep;
        wrCtl |=> sleepActive == $past(regReq.wdata[10]);
    endproperty
    a_sleep: assert property (p_sleep) else $error("Sleep state does not follow the written bit");
    property p_mode;
        wrCtl && !busoffStatusFlag |=> modeActive == $past(regReq.wdata[9:8]);
    endproperty
    a_mode: assert property (p_mode) else $error("Mode does not follow the written field");
    property p_reset_prio;
        wrCtl && regReq.wdata[9:8] == 2'b01 |=> modeActive == 2'b01;
    endproperty
    a_reset_prio: assert property (p_reset_prio) else $error("Reset request lost to halt entry");
    property p_busoff_cause;
        $rose(busoffStatusFlag) |-> $past(errEvent.txInc) != 4'h0;
    endproperty
    a_busoff_cause: assert property (p_busoff_cause) else $error("Bus-off without transmit errors");
    property p_passive;
        busoffStatusFlag |-> !errorPassive;
    endproperty
    a_passive: assert property (p_passive) else $error("Passive flag set while bus-off");
    property p_passive_entry;
        $rose(busoffStatusFlag) |-> $past(errorPassive);
    endproperty
    a_passive_entry: assert property (p_passive_entry) else $error("Bus-off entered from error-active");
endmodule : cbrc_ctrl_props

bind cbrc_ctrl cbrc_ctrl_props u_props (.clk(clk), .resetn(resetn), .regReq(regReq), .regRdata(regRdata),
    .errEvent(errEvent), .bitTick(bitTick), .canRx(canRx), .busoffStatusFlag(busoffStatusFlag),
    .errorPassive(errorPassive), .modeActive(modeActive), .sleepActive(sleepActive), .recoveryIrq(recoveryIrq));

// ---- cbrc_pkg.sv ----
/*
 * Shared constants and types for the bus-off recovery and mode control of one CAN channel.
 * Assumes a 16-bit CPU register port and a protocol engine that reports error-counter events.
 */
package cbrc_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL = 32'hffffa840;
    localparam logic [31:0] ADDR_REC  = 32'hffffa84e;
    localparam logic [31:0] ADDR_TEC  = 32'hffffa84f;

    // Control register field positions
    localparam int BIT_FORCED_RETURN = 13;
    localparam int POS_POLICY        = 11;
    localparam int BIT_SLEEP         = 10;
    localparam int POS_MODE          = 8;
    localparam int BIT_TS_RESET      = 5;

    // Values after reset and the reserved-bit mask
    localparam logic [15:0] CTRL_RESET  = 16'h0500;
    localparam logic [7:0]  COUNT_RESET = 8'h00;
    localparam logic [15:0] RESERVED_MASK = 16'hc000;

    // Recovery sequence counts
    localparam logic [3:0] RECESSIVE_RUN = 4'hb;
    localparam logic [7:0] RECOVERY_RUNS = 8'h80;

    // Error-state thresholds
    localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h0ff;

    typedef enum logic [1:0] {
        MODE_OPERATION = 2'b00,
        MODE_RESET     = 2'b01,
        MODE_HALT      = 2'b10,
        MODE_FORCED    = 2'b11
    } cbrc_mode_type;

    typedef enum logic [1:0] {
        POLICY_NORMAL     = 2'b00,
        POLICY_HALT_ENTRY = 2'b01,
        POLICY_HALT_END   = 2'b10,
        POLICY_PROGRAM    = 2'b11
    } cbrc_policy_type;

    typedef enum {
        ERR_ACTIVE,
        ERR_PASSIVE,
        ERR_BUSOFF
    } cbrc_err_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [1:0]  byteEn;
        logic [31:0] addr;
        logic [15:0] wdata;
    } cbrc_req_type;

    typedef struct packed {
        logic [3:0] txInc;
        logic [3:0] rxInc;
        logic       txDec;
        logic       rxDec;
    } cbrc_event_type;

endpackage : cbrc_pkg

// ---- cbrc_recovery_seq.sv ----
/*
 * Counts runs of consecutive recessive bits while the channel is bus-off.
 * Assumes bitTick is a one-cycle pulse per bit time and recessive is already synchronised.
 */
`timescale 1ns/1ps
module cbrc_recovery_seq (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Sequence control
    input  wire logic enable,
    input  wire logic bitTick,
    input  wire logic recessive,
    // Result
    output logic      done
);

    typedef struct packed {
        logic [3:0] run;
        logic [7:0] runs;
        logic       done;
    } cbrc_seq_state_type;

    cbrc_seq_state_type state;
    cbrc_seq_state_type next_state;

    always_comb begin
        next_state      = state;
        next_state.done = 1'b0;
        if (!enable) begin
            next_state.run  = 4'h0;
            next_state.runs = 8'h00;
        end else if (bitTick) begin
            if (!recessive) begin
                next_state.run = 4'h0;
            end else if (state.run == cbrc_pkg::RECESSIVE_RUN - 4'h1) begin
                // A dominant bit inside a run restarts only that run, not the tally
                next_state.run = 4'h0;
                if (state.runs == cbrc_pkg::RECOVERY_RUNS - 8'h01) begin
                    next_state.runs = 8'h00;
                    next_state.done = 1'b1;
                end else begin
                    next_state.runs = state.runs + 8'h01;
                end
            end else begin
                next_state.run = state.run + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign done = state.done;

endmodule : cbrc_recovery_seq

// ---- tb_cbrc_ctrl.sv ----
/* Self-checking bench for the channel control block.
   Assumes the bus stand-in supplies bit ticks; the bench plays the CPU and the protocol engine. */
`timescale 1ns/1ps
module tb_cbrc_ctrl;
    logic                     clk = 1'b0;
    logic                     resetn = 1'b0;
    cbrc_pkg::cbrc_req_type   regReq = '0;
    cbrc_pkg::cbrc_event_type errEvent = '0;
    logic                     run = 1'b0;
    logic                     bitTick;
    logic                     canRx;
    logic [15:0]              regRdata;
    logic                     busoffStatusFlag;
    logic                     errorPassive;
    logic [1:0]               modeActive;
    logic                     sleepActive;
    logic                     recoveryIrq;
    int                       n_mismatch = 0;
    int                       cmp_count = 0;
    int                       irqN = 0;

    cbrc_ctrl uut (.clk(clk), .resetn(resetn), .regReq(regReq), .regRdata(regRdata), .errEvent(errEvent),
        .bitTick(bitTick), .canRx(canRx), .busoffStatusFlag(busoffStatusFlag), .errorPassive(errorPassive),
        .modeActive(modeActive), .sleepActive(sleepActive), .recoveryIrq(recoveryIrq));
    cbrc_bus_node #(.TICK_DIV(2)) node (.clk(clk), .run(run), .bitTick(bitTick), .canRx(canRx));

    initial forever #25 clk = ~clk;
    always @(posedge clk) if (recoveryIrq === 1'b1) irqN <= irqN + 1;

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [15:0] ctl(input logic [1:0] pol, input logic slp, input logic [1:0] md);
        return {3'b000, pol, slp, md, 8'h00};
    endfunction : ctl
    task automatic rst;
        @(posedge clk) resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        irqN = 0;
    endtask : rst
    task automatic wr(input logic [15:0] d);
        @(posedge clk) regReq <= '{1'b1, 1'b0, 2'b11, cbrc_pkg::ADDR_CTRL, d};
        @(posedge clk) regReq.write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clk) regReq <= '{1'b0, 1'b1, 2'b11, a, 16'h0000};
        @(posedge clk) regReq.read <= 1'b0;
        #1 chk(regRdata, exp);
    endtask : rd
    task automatic opMode(input logic [1:0] pol);
        wr(16'h0100);
        wr(ctl(pol, 1'b0, 2'b01));
        wr(ctl(pol, 1'b0, 2'b00));
    endtask : opMode
    // Pushes the transmit count past its limit; events after entry must be ignored
    task automatic bo;
        for (int i = 0; i < 40 && busoffStatusFlag !== 1'b1; i++) begin
            @(posedge clk) errEvent <= '{4'hf, 4'h1, 1'b0, 1'b0};
            #1;
        end
        @(posedge clk) errEvent <= '0;
        #1 if (busoffStatusFlag !== 1'b1) begin n_mismatch++; stop_test(); end
    endtask : bo
    task automatic recover;
        int i;
        @(posedge clk) run <= 1'b1;
        for (i = 0; i < 4000 && busoffStatusFlag === 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk) run <= 1'b0;
        if (i == 4000) begin n_mismatch++; stop_test(); end
        // Two cycles per tick from the bus stand-in, plus sequencer and flag latency
        chk(16'(i), 16'(int'(cbrc_pkg::RECOVERY_RUNS) * int'(cbrc_pkg::RECESSIVE_RUN) * 2 + 2));
        repeat (2) @(posedge clk);
        #1;
    endtask : recover

    task automatic t_forced;
        rst();
        rd(cbrc_pkg::ADDR_CTRL, 16'h0500);
        rd(32'hffffa850, 16'h0000);
        chk(16'(modeActive), 16'h0001);
        opMode(2'b00);
        #1 chk(16'(sleepActive), 16'h0000);
        bo();
        rd(cbrc_pkg::ADDR_TEC, 16'h00ff);
        wr(16'h2000);
        #1 chk(16'(busoffStatusFlag), 16'h0000);
        rd(cbrc_pkg::ADDR_CTRL, 16'h0000);
        rd(cbrc_pkg::ADDR_REC, 16'h0000);
        rd(cbrc_pkg::ADDR_TEC, 16'h0000);
        chk(16'(irqN), 16'h0000);
        wr(16'h0100);
        wr(16'h0500);
        #1 chk(16'(sleepActive), 16'h0001);
        $display("Test forced return done");
    endtask : t_forced
    task automatic t_policies;
        logic [1:0] m;
        for (int p = 0; p < 3; p++) begin
            m = (p == 0) ? 2'b00 : 2'b10;
            rst();
            opMode(2'(p));
            bo();
            chk(16'(modeActive), (p == 1) ? 16'h0002 : 16'h0000);
            rd(cbrc_pkg::ADDR_CTRL, ctl(2'(p), 1'b0, m));
            rd(cbrc_pkg::ADDR_TEC, (p == 1) ? 16'h0000 : 16'h00ff);
            recover();
            chk(16'(irqN), (p == 1) ? 16'h0000 : 16'h0001);
            chk(16'(modeActive), 16'(m));
            if (p != 0) rd(cbrc_pkg::ADDR_TEC, 16'h0000);
        end
        $display("Test recovery policies done");
    endtask : t_policies
    task automatic t_prog;
        rst();
        opMode(2'b11);
        bo();
        wr(ctl(2'b11, 1'b0, 2'b10));
        #1 chk(16'(modeActive), 16'h0002);
        rd(cbrc_pkg::ADDR_TEC, 16'h0000);
        recover();
        chk(16'(irqN), 16'h0000);
        rst();
        opMode(2'b11);
        bo();
        recover();
        chk(16'(irqN), 16'h0001);
        $display("Test program halt done");
    endtask : t_prog
    // The last error edge and the reset request land on the same clock edge
    task automatic t_prio;
        rst();
        opMode(2'b01);
        repeat (17) @(posedge clk) errEvent <= '{4'hf, 4'h0, 1'b0, 1'b0};
        @(posedge clk) regReq <= '{1'b1, 1'b0, 2'b11, cbrc_pkg::ADDR_CTRL, ctl(2'b01, 1'b0, 2'b01)};
        #1 chk(16'(errorPassive), 16'h0001);
        @(posedge clk) begin
            regReq.write <= 1'b0;
            errEvent <= '0;
        end
        #1 chk(16'(busoffStatusFlag), 16'h0001);
        chk(16'(modeActive), 16'h0001);
        $display("Test reset priority done");
    endtask : t_prio

    initial begin
        t_forced();
        t_policies();
        t_prog();
        t_prio();
        stop_test();
    end
endmodule : tb_cbrc_ctrl
